// *** rtl/sdmr_mode_regs.sv ***
// mode register zero/one decode, dll control and burst order
`timescale 1ns/100ps
`default_nettype none
module sdmr_mode_regs
  import sdmr_pkg::*;
(
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_reset_n,
  // mode set command
  input  wire logic             i_mode_set,
  input  wire logic [BANK_W-1:0] i_bank,
  input  wire logic [MR_W-1:0]  i_addr,
  // column commands
  input  wire logic             i_read,
  input  wire logic             i_write,
  input  wire logic [COL_W-1:0] i_col,
  input  wire logic             i_burst_select,
  output logic                  o_cmd_ready,
  // power state events
  input  wire logic             i_sr_enter,
  input  wire logic             i_sr_exit,
  input  wire logic             i_pd_enter,
  input  wire logic             i_pd_exit,
  // beat stream
  output logic                  o_beat_valid,
  output logic [COL_W-1:0]      o_beat_col,
  output logic                  o_beat_drive,
  output logic                  o_beat_write,
  output logic                  o_beat_used,
  input  wire logic             i_beat_ready,
  // decoded settings
  output logic [1:0]            o_burst_mode,
  output logic                  o_interleaved,
  output logic [LAT_W-1:0]      o_read_latency,
  output logic [LAT_W-1:0]      o_write_recovery,
  output logic                  o_pd_slow_exit,
  output logic                  o_rtt_all_ok,
  output logic                  o_rtt_write_only,
  output logic                  o_outputs_off,
  output logic                  o_mode_busy,
  // dll status
  output logic                  o_dll_enabled,
  output logic                  o_dll_running,
  output logic                  o_dll_reset,
  output logic                  o_dll_locked
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [MR_W-1:0]  mr0;
    logic [MR_W-1:0]  mr1;
    logic [MR_W-1:0]  pend;
    logic             pend_mr1;
    logic             pend_vld;
    logic [MOD_W-1:0] mod_cnt;
    logic             dll_on;
    logic             in_sr;
    logic             in_pd;
    logic             locking;
    logic             locked;
    logic [LOCK_W-1:0] lock_cnt;
    logic             dll_rst;
    logic             running;
    sdmr_seq_t        seq;
    logic [LAT_W-1:0] lat_cnt;
    logic [2:0]       beat;
    logic [COL_W-1:0] start;
    logic             chop;
    logic             wr;
    logic             cmd_rdy;
    logic [LAT_W-1:0] rl;
    logic [LAT_W-1:0] wrec;
    logic             rtt_all;
    logic             rtt_wonly;
  } sdmr_core_st_t;

  // ==========
  // beat word: used, drive, write, column
  localparam int BW = COL_W + 3;

  sdmr_core_st_t   q;
  sdmr_core_st_t   d;
  logic            buf_rdy;
  logic            push;
  logic [BW-1:0]   push_data;
  logic [BW-1:0]   pop_data;
  logic [2:0]      lo_col;
  logic            used;
  logic [LAT_W-1:0] cl_code;

  // ==========================================================
  // beat column generation
  always_comb begin
    if (q.mr0[MR0_BT]) begin
      lo_col = q.start[2:0] ^ q.beat;
    end else begin
      lo_col = {q.start[2] ^ q.beat[2],
                q.start[1:0] + q.beat[1:0]};
    end
    // chopped tail slots carry no data in either direction
    used      = !(q.chop && q.beat[2]);
    push      = (q.seq == SEQ_BURST);
    push_data = {used, used & ~q.wr, q.wr,
                 q.start[COL_W-1:3], lo_col};
  end

  // ==========================================================
  // next state
  always_comb begin
    logic start_rst;
    logic is_chop;
    logic take_rd;
    start_rst = 1'b0;
    is_chop   = 1'b0;
    take_rd   = 1'b0;
    cl_code   = 4'h0;
    d         = q;
    d.dll_rst = 1'b0;

    // ==========
    // settle delay before a captured value takes effect
    if (q.pend_vld) begin
      if (q.mod_cnt != '0) begin
        d.mod_cnt = q.mod_cnt - 4'h1;
      end else begin
        d.pend_vld = 1'b0;
        if (!q.pend_mr1) begin
          // reset bit is acted on, never stored
          d.mr0 = q.pend & ~MR0_RSVD
                & ~(19'h1 << MR0_DLL_RST);
          start_rst = q.pend[MR0_DLL_RST];
        end else begin
          d.mr1    = q.pend & ~MR1_RSVD;
          d.dll_on = !q.pend[MR1_DLL_DIS];
          if (q.pend[MR1_DLL_DIS]) begin
            d.locked  = 1'b0;
            d.locking = 1'b0;
          end
        end
      end
    end

    // ==========
    // a later mode set replaces one still settling
    if (i_mode_set && (i_bank == BANK_MR0 ||
                       i_bank == BANK_MR1)) begin
      d.pend     = i_addr;
      d.pend_mr1 = (i_bank == BANK_MR1);
      d.pend_vld = 1'b1;
      d.mod_cnt  = MOD_CYCLES - 4'h1;
    end

    // ==========
    // self refresh parks an enabled dll and revives it
    if (i_sr_enter && !q.in_sr) begin
      d.in_sr   = 1'b1;
      d.dll_on  = 1'b0;
      d.locked  = 1'b0;
      d.locking = 1'b0;
    end else if (i_sr_exit && q.in_sr) begin
      d.in_sr = 1'b0;
      if (!d.mr1[MR1_DLL_DIS]) begin
        d.dll_on  = 1'b1;
        start_rst = 1'b1;
      end
    end

    // ==========
    // precharge power-down tracking
    if (i_pd_enter) begin
      d.in_pd = 1'b1;
    end else if (i_pd_exit) begin
      d.in_pd = 1'b0;
    end

    // ==========
    // lock wait; reads before it ends see invalid timing
    if (start_rst && d.dll_on) begin
      d.dll_rst  = 1'b1;
      d.locking  = 1'b1;
      d.locked   = 1'b0;
      d.lock_cnt = DLLK_LAST;
    end else if (q.locking && d.dll_on) begin
      if (q.lock_cnt == '0) begin
        d.locking = 1'b0;
        d.locked  = 1'b1;
      end else begin
        d.lock_cnt = q.lock_cnt - 10'h1;
      end
    end

    // ==========
    // dll stops in precharge power-down only when bit clear
    d.running = d.dll_on && !d.in_sr &&
                !(d.in_pd && !d.mr0[MR0_PPD]);

    // ==========
    // decoded settings follow the applied registers
    cl_code = {d.mr0[MR0_CL_EXT],
               d.mr0[MR0_CL_LSB +: 3]};
    if (cl_code >= CL_CODE_MIN &&
        cl_code <= CL_CODE_MAX) begin
      d.rl = cl_code + CL_OFFSET;
    end else begin
      d.rl = CL_MIN;
    end
    d.wrec      = WR_TABLE[d.mr0[MR0_WR_LSB +: 3]];
    d.rtt_all   = d.mr1[MR1_WLVL] &
                  d.mr1[MR1_QOFF];
    d.rtt_wonly = d.mr1[MR1_WLVL] &
                  ~d.mr1[MR1_QOFF];

    // ==========
    // burst sequencer
    unique case (q.seq)
      SEQ_IDLE: begin
        // commands are only taken while idle
        if (i_read || i_write) begin
          take_rd = i_read;
          unique case (q.mr0[MR0_BL_LSB +: 2])
            BL_OTF:   is_chop = !i_burst_select;
            BL_CHOP4: is_chop = 1'b1;
            default:  is_chop = 1'b0;
          endcase
          d.chop = is_chop;
          d.wr   = !take_rd;
          d.beat = 3'h0;
          if (take_rd) begin
            d.start   = i_col;
            d.lat_cnt = q.rl - RD_PIPE;
          end else begin
            // low write address bits are don't-care
            d.start = {i_col[COL_W-1:3],
                       i_col[2] & is_chop, 2'h0};
            d.lat_cnt = 4'h0;
          end
          d.seq = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        // reads count down the latency, writes pass at once
        if (q.lat_cnt == 4'h0) begin
          d.seq = SEQ_BURST;
        end else begin
          d.lat_cnt = q.lat_cnt - 4'h1;
        end
      end
      SEQ_BURST: begin
        // all eight slots run for both lengths
        if (buf_rdy) begin
          d.beat = q.beat + 3'h1;
          if (q.beat == BEAT_LAST) begin
            d.seq = SEQ_IDLE;
          end
        end
      end
      default: begin
        d.seq = SEQ_IDLE;
      end
    endcase
    d.cmd_rdy = (d.seq == SEQ_IDLE);
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '{
        mr0:       MR0_RST,
        mr1:       MR1_RST,
        pend:      '0,
        pend_mr1:  1'b0,
        pend_vld:  1'b0,
        mod_cnt:   '0,
        dll_on:    1'b1,
        in_sr:     1'b0,
        in_pd:     1'b0,
        locking:   1'b0,
        locked:    1'b0,
        lock_cnt:  '0,
        dll_rst:   1'b0,
        running:   1'b1,
        seq:       SEQ_IDLE,
        lat_cnt:   '0,
        beat:      '0,
        start:     '0,
        chop:      1'b0,
        wr:        1'b0,
        cmd_rdy:   1'b1,
        rl:        CL_MIN,
        wrec:      4'h0,
        rtt_all:   1'b0,
        rtt_wonly: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // beat buffer; a stalled receiver halts the sequencer
  sdmr_skid2 #(
    .W (BW)
  ) u_buf (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_valid    (push),
    .i_data     (push_data),
    .o_ready    (buf_rdy),
    .o_valid    (o_beat_valid),
    .o_data     (pop_data),
    .i_ready    (i_beat_ready)
  );

  // ==========================================================
  // outputs, all straight from flops
  // beat stream from the buffer head
  assign o_beat_used      = pop_data[BW-1];
  assign o_beat_drive     = pop_data[BW-2];
  assign o_beat_write     = pop_data[BW-3];
  assign o_beat_col       = pop_data[COL_W-1:0];
  assign o_cmd_ready      = q.cmd_rdy;
  // settings and dll status
  assign o_burst_mode     = q.mr0[MR0_BL_LSB +: 2];
  assign o_interleaved    = q.mr0[MR0_BT];
  assign o_read_latency   = q.rl;
  assign o_write_recovery = q.wrec;
  assign o_pd_slow_exit   = ~q.mr0[MR0_PPD];
  assign o_rtt_all_ok     = q.rtt_all;
  assign o_rtt_write_only = q.rtt_wonly;
  assign o_outputs_off    = q.mr1[MR1_QOFF];
  assign o_mode_busy      = q.pend_vld;
  assign o_dll_enabled    = q.dll_on;
  assign o_dll_running    = q.running;
  assign o_dll_reset      = q.dll_rst;
  assign o_dll_locked     = q.locked;

endmodule : sdmr_mode_regs
`default_nettype wire

// *** rtl/sdmr_pkg.sv ***
// constants and types for the mode register zero/one block
// Function
// - mode reg zero reserved bits held zero
// - bit 3 picks sequential or interleaved
// - sequential read wraps low bits per nibble
// - interleaved read column is start xor beat
// - writes start on nibble or word boundary
// - ignored write address bits have no effect
// - chopped read tail slots drivers off
// - chopped and full bursts start together
// - dll reset bit self clears after start
// - bits 11:9 select write recovery cycles
// - bit 12 keeps dll in power-down
// - read latency five to fourteen whole clocks
// - first read data at edge n plus latency
// - mode reg one holds until rewritten or reset
// - mode reg one reserved bits held zero
// - write leveling termination set by bit 12
// - bit 0 enables or disables the dll
// - self refresh stops then restarts dll
// - disabled dll stays off after self refresh
// - burst length code, on-the-fly select bit
// - burst block from upper column bits
package sdmr_pkg;

  // ==========================================================
  // widths
  localparam int MR_W   = 19;
  localparam int COL_W  = 10;
  localparam int BANK_W = 3;
  localparam int LAT_W  = 4;
  localparam int LOCK_W = 10;
  localparam int MOD_W  = 4;

  // ==========================================================
  // field positions
  localparam int MR0_BL_LSB   = 0;
  localparam int MR0_CL_EXT   = 2;
  localparam int MR0_BT       = 3;
  localparam int MR0_CL_LSB   = 4;
  localparam int MR0_DLL_RST  = 8;
  localparam int MR0_WR_LSB   = 9;
  localparam int MR0_PPD      = 12;
  localparam int MR1_DLL_DIS  = 0;
  localparam int MR1_WLVL     = 7;
  localparam int MR1_QOFF     = 12;

  // ==========================================================
  // reserved masks, reset values, selects
  localparam logic [MR_W-1:0]   MR0_RSVD = 19'h4e080;
  localparam logic [MR_W-1:0]   MR1_RSVD = 19'h4e500;
  localparam logic [MR_W-1:0]   MR0_RST  = 19'h00000;
  localparam logic [MR_W-1:0]   MR1_RST  = 19'h00000;
  localparam logic [BANK_W-1:0] BANK_MR0 = 3'h0;
  localparam logic [BANK_W-1:0] BANK_MR1 = 3'h1;
  localparam logic [1:0]        BL_FULL8 = 2'h0;
  localparam logic [1:0]        BL_OTF   = 2'h1;
  localparam logic [1:0]        BL_CHOP4 = 2'h2;

  // ==========================================================
  // latency and recovery decode
  localparam logic [LAT_W-1:0] CL_OFFSET   = 4'h4;
  localparam logic [LAT_W-1:0] CL_CODE_MIN = 4'h1;
  localparam logic [LAT_W-1:0] CL_CODE_MAX = 4'ha;
  localparam logic [LAT_W-1:0] CL_MIN      = 4'h5;
  localparam logic [LAT_W-1:0] RD_PIPE     = 4'h2;
  localparam logic [LAT_W-1:0] WR_TABLE [8] = '{
    4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h0};

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MOD_NS        = 15;
  localparam int MOD_MIN_CK    = 12;
  localparam int MOD_TIME_CK   =
    (MOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [MOD_W-1:0] MOD_CYCLES = MOD_W'(
    (MOD_TIME_CK > MOD_MIN_CK) ? MOD_TIME_CK : MOD_MIN_CK);
  localparam logic [LOCK_W-1:0] DLLK_LAST = 10'h1ff;
  localparam logic [2:0]        BEAT_LAST = 3'h7;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_WAIT  = 2'b01,
    SEQ_BURST = 2'b10
  } sdmr_seq_t;

endpackage : sdmr_pkg

// *** rtl/sdmr_skid2.sv ***
// two-entry beat buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sdmr_skid2
  import sdmr_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  // fill side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // drain side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0]   cnt;
    logic         vld;
    logic         rdy;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } sdmr_skid_t;

  sdmr_skid_t q;
  sdmr_skid_t d;

  // ==========================================================
  // next state; head entry is the output register itself
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop  = 1'b0;
    d    = q;
    push = i_valid & q.rdy;
    pop  = q.vld & i_ready;
    if (push && !pop) begin
      if (q.cnt == 2'h0) begin
        d.e0 = i_data;
      end else begin
        d.e1 = i_data;
      end
      d.cnt = q.cnt + 2'h1;
    end else if (pop && !push) begin
      d.e0  = q.e1;
      d.cnt = q.cnt - 2'h1;
    end else if (pop && push) begin
      if (q.cnt == 2'h1) begin
        d.e0 = i_data;
      end else begin
        d.e0 = q.e1;
        d.e1 = i_data;
      end
    end
    d.vld = (d.cnt != 2'h0);
    d.rdy = (d.cnt != 2'h2);
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '{cnt: 2'h0, vld: 1'b0, rdy: 1'b1,
             e0: '0, e1: '0};
    end else begin
      q <= d;
    end
  end

  assign o_ready = q.rdy;
  assign o_valid = q.vld;
  assign o_data  = q.e0;

endmodule : sdmr_skid2
`default_nettype wire

// *** sim/sdmr_beat_sink.sv ***
// beat receiver standing in for the controller data path
`timescale 1ns/100ps
`default_nettype none
module sdmr_beat_sink (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  // beat stream and stall control
  input  wire logic        i_valid,
  input  wire logic [12:0] i_beat,
  input  wire logic        i_hold,
  output logic             o_ready
);
  // ========================================
  // random stalls, no kinder than a busy controller
  logic [7:0]  st_q;
  logic [12:0] q[$];
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q    <= 8'h5a;
      o_ready <= 1'b0;
    end else begin
      st_q    <= {st_q[6:0], st_q[7] ^ st_q[5] ^ st_q[4] ^ st_q[3]};
      o_ready <= !i_hold && (st_q[0] || st_q[2]);
    end
  end
  // sampled mid-cycle, where both sides are settled
  always @(negedge i_core_clk) begin
    if (i_valid && o_ready) begin
      q.push_back(i_beat);
    end
  end
endmodule : sdmr_beat_sink
`default_nettype wire

// *** sim/sdmr_checker.sv ***
// port-level assertions for the mode register block
`timescale 1ns/100ps
`default_nettype none
module sdmr_checker
  import sdmr_pkg::*;
(
  // clock and reset
  input wire logic              i_core_clk,
  input wire logic              i_reset_n,
  // requests
  input wire logic              i_mode_set,
  input wire logic [BANK_W-1:0] i_bank,
  input wire logic              i_beat_ready,
  // beat stream
  input wire logic              o_beat_valid,
  input wire logic [COL_W-1:0]  o_beat_col,
  input wire logic              o_beat_drive,
  input wire logic              o_beat_write,
  input wire logic              o_beat_used,
  // settings and dll
  input wire logic [LAT_W-1:0]  o_read_latency,
  input wire logic [LAT_W-1:0]  o_write_recovery,
  input wire logic              o_rtt_all_ok,
  input wire logic              o_rtt_write_only,
  input wire logic              o_outputs_off,
  input wire logic              o_mode_busy,
  input wire logic              o_dll_enabled,
  input wire logic              o_dll_running,
  input wire logic              o_dll_reset,
  input wire logic              o_dll_locked
);
  // beats come in groups of eight, so count them
  logic [2:0] beat_idx_q;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      beat_idx_q <= 3'h0;
    end else if (o_beat_valid && i_beat_ready) begin
      beat_idx_q <= beat_idx_q + 3'h1;
    end
  end
  // ========================================
  // sequences
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_set;
    i_mode_set && (i_bank == BANK_MR0 || i_bank == BANK_MR1);
  endsequence
  sequence s_stall;
    o_beat_valid && !i_beat_ready;
  endsequence
  // ========================================
  // properties
  chk_busy_wait: assert property (
    s_set |=> o_mode_busy [*8]) else $error("mode wait cut short");
  // a stalled head must not move, or the receiver loses a word
  chk_beat_hold: assert property (
    s_stall |=> o_beat_valid && $stable(o_beat_col)
      && $stable(o_beat_write)) else $error("stalled beat changed");
  chk_reset_pulse: assert property (
    o_dll_reset |=> !o_dll_reset && !o_dll_locked)
    else $error("dll reset not self clearing");
  chk_lat_range: assert property (
    o_read_latency >= CL_MIN && o_read_latency <= 4'he)
    else $error("latency out of range");
  chk_wr_codes: assert property (
    o_write_recovery inside {4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc})
    else $error("bad write recovery");
  chk_wlvl_term: assert property (
    (o_rtt_all_ok || o_rtt_write_only) |-> !(o_rtt_all_ok
      && o_rtt_write_only) && (o_rtt_all_ok == o_outputs_off))
    else $error("termination choice wrong");
  chk_write_align: assert property (
    o_beat_valid && o_beat_write |-> o_beat_col[1:0] == beat_idx_q[1:0]
      && !o_beat_drive) else $error("write beat misaligned");
  chk_tail_off: assert property (
    o_beat_valid && !o_beat_used |-> !o_beat_drive)
    else $error("driver on in tail slot");
  chk_dll_run: assert property (
    o_dll_running |-> o_dll_enabled) else $error("dll runs disabled");
endmodule : sdmr_checker

bind sdmr_mode_regs sdmr_checker u_sdmr_checker (
  .i_core_clk, .i_reset_n, .i_mode_set, .i_bank, .i_beat_ready,
  .o_beat_valid, .o_beat_col, .o_beat_drive, .o_beat_write, .o_beat_used,
  .o_read_latency, .o_write_recovery, .o_rtt_all_ok, .o_rtt_write_only,
  .o_outputs_off, .o_mode_busy, .o_dll_enabled, .o_dll_running,
  .o_dll_reset, .o_dll_locked);
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the mode register block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import sdmr_pkg::*;
;
  logic i_core_clk, i_reset_n, i_mode_set, i_read, i_write, i_burst_select;
  logic i_sr_enter, i_sr_exit, i_pd_enter, i_pd_exit, i_beat_ready, hold;
  logic o_cmd_ready, o_beat_valid, o_beat_drive, o_beat_write, o_beat_used;
  logic o_interleaved, o_pd_slow_exit, o_rtt_all_ok, o_rtt_write_only;
  logic o_outputs_off, o_mode_busy, o_dll_enabled, o_dll_running;
  logic o_dll_reset, o_dll_locked;
  logic [BANK_W-1:0] i_bank;
  logic [MR_W-1:0]   i_addr;
  logic [COL_W-1:0]  i_col, o_beat_col;
  logic [1:0]        o_burst_mode;
  logic [LAT_W-1:0]  o_read_latency, o_write_recovery;
  logic [31:0]       rs;
  int                n_errors, samples_checked;

  sdmr_mode_regs u_sdmr_mode_regs (.i_core_clk, .i_reset_n, .i_mode_set,
    .i_bank, .i_addr, .i_read, .i_write, .i_col, .i_burst_select,
    .o_cmd_ready, .i_sr_enter, .i_sr_exit, .i_pd_enter, .i_pd_exit,
    .o_beat_valid, .o_beat_col, .o_beat_drive, .o_beat_write, .o_beat_used,
    .i_beat_ready, .o_burst_mode, .o_interleaved, .o_read_latency,
    .o_write_recovery, .o_pd_slow_exit, .o_rtt_all_ok, .o_rtt_write_only,
    .o_outputs_off, .o_mode_busy, .o_dll_enabled, .o_dll_running,
    .o_dll_reset, .o_dll_locked);
  sdmr_beat_sink u_sdmr_beat_sink (.i_core_clk, .i_reset_n,
    .i_valid(o_beat_valid), .i_hold(hold), .o_ready(i_beat_ready),
    .i_beat({o_beat_write, o_beat_used, o_beat_drive, o_beat_col}));

  // ========================================
  // helpers
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    repeat (8) s = {s[30:0], ^(s & 32'h80200003)};
    return s;
  endfunction
  function automatic logic [18:0] mr0(input logic [1:0] bl, input logic bt,
    input logic [3:0] cl, input logic [2:0] wr, input logic dr, pd);
    return {6'h0, pd, wr, dr, 1'b0, cl[2:0], bt, cl[3], bl};
  endfunction
  function automatic logic [3:0] exp_cl(input logic [3:0] c);
    return (c >= 4'h1 && c <= 4'ha) ? c + 4'h4 : 4'h5;
  endfunction
  function automatic logic [3:0] exp_wr(input logic [2:0] c);
    return (c == 3'h0 || c == 3'h7) ? 4'h0 : (c < 3'h5) ? c + 4'h4 : c * 2;
  endfunction
  function automatic logic [9:0] exp_col(input logic [9:0] s,
    input logic [2:0] b, input logic il, wr, ch);
    logic [2:0] lo;
    lo = wr ? {ch & s[2], 2'h0} : s[2:0];
    lo = il ? lo ^ b : {lo[2] ^ b[2], lo[1:0] + b[1:0]};
    return {s[9:3], lo};
  endfunction
  task automatic final_report;
    $display("mismatches %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task automatic compare(input logic [15:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask : compare
  task automatic give_up(input string what);
    compare(16'h0, 16'h1, what);
    final_report();
  endtask : give_up
  task automatic cyc;
    @(posedge i_core_clk);
    #2;
  endtask : cyc
  task automatic wait_hi(ref logic s, input int lim, output int k);
    for (k = 0; k < lim && s !== 1'b1; k++) cyc();
    if (k == lim) give_up("wait ran out");
  endtask : wait_hi
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc();
    s = 1'b0;
    cyc();
  endtask : pulse
  task automatic ms(input logic [2:0] b, input logic [18:0] v, input bit w);
    int k;
    i_bank = b;
    i_addr = v;
    i_mode_set = 1'b1;
    cyc();
    i_mode_set = 1'b0;
    compare(o_mode_busy, b < 3'h2, "busy");
    if (w && b < 3'h2) begin
      for (k = 0; k < 20 && o_mode_busy !== 1'b0; k++) cyc();
      compare(k[15:0], MOD_CYCLES, "apply delay");
    end
  endtask : ms
  task automatic burst(input logic [1:0] bl, input logic bt,
    input logic [3:0] cl, input logic wr, input logic [9:0] col,
    input logic bs, hd);
    int k;
    logic ch;
    logic [12:0] e;
    ms(3'h0, mr0(bl, bt, cl, 3'h1, 1'b0, 1'b1), 1'b1);
    compare({o_burst_mode, o_interleaved}, {bl, bt}, "mode");
    ch = bl == BL_CHOP4 || (bl == BL_OTF && !bs);
    u_sdmr_beat_sink.q.delete();
    hold = hd;
    i_col = col;
    i_burst_select = bs;
    {i_read, i_write} = {!wr, wr};
    cyc();
    {i_read, i_write} = 2'b01;
    compare(o_cmd_ready, 1'b0, "busy ready");
    cyc();
    i_write = 1'b0;
    wait_hi(o_beat_valid, 40, k);
    compare(k + 1, wr ? 2 : exp_cl(cl), "latency");
    repeat (16 * hd) cyc();
    hold = 1'b0;
    for (k = 0; k < 80 && u_sdmr_beat_sink.q.size() < 8; k++) cyc();
    if (k == 80) give_up("beats missing");
    for (k = 0; k < 8; k++) begin
      e = u_sdmr_beat_sink.q[k];
      compare(e[12:10], {wr, !(ch && k > 3), !wr && !(ch && k > 3)},
        "beat flags");
      if (!(ch && k > 3)) begin
        compare(e[9:0], exp_col(col, k[2:0], bt, wr, ch),
          "column");
      end
    end
    wait_hi(o_cmd_ready, 20, k);
    repeat (5) cyc();
    compare(16'(u_sdmr_beat_sink.q.size()), 16'h8, "beat count");
  endtask : burst

  // ========================================
  // main sequence
  initial begin
    int j, k;
    {i_mode_set, i_read, i_write, i_burst_select, i_sr_enter} = '0;
    {i_sr_exit, i_pd_enter, i_pd_exit, hold, i_reset_n} = '0;
    {i_bank, i_addr, i_col} = '0;
    rs = 32'h00015205;
    repeat (12) @(posedge i_core_clk);
    #2 i_reset_n = 1'b1;
    compare({o_read_latency, o_write_recovery, o_dll_enabled, o_dll_locked,
      o_pd_slow_exit, o_cmd_ready}, 12'h50b, "reset");
    for (j = 0; j < 4; j++) begin
      ms(3'h1, {6'h0, j[1], 4'h0, j[0], 7'h0}, 1'b1);
      compare({o_rtt_all_ok, o_rtt_write_only, o_outputs_off},
        {j[0] & j[1], j[0] & !j[1], j[1]}, "termination");
    end
    for (j = 0; j < 16; j++) begin
      ms(3'h0, mr0(2'h0, 1'b0, j[3:0], j[2:0], 1'b0, j[0]) | MR0_RSVD, 1'b1);
      compare(o_read_latency, exp_cl(j[3:0]), "latency");
      compare(o_write_recovery, exp_wr(j[2:0]), "recovery");
      compare(o_pd_slow_exit, !j[0], "pd exit");
    end
    ms(3'h2, mr0(2'h0, 1'b0, 4'h3, 3'h3, 1'b1, 1'b0), 1'b0);
    repeat (14) cyc();
    compare(o_read_latency, 4'h5, "other bank");
    compare(o_outputs_off, 1'b1, "mr1 kept");
    ms(3'h0, mr0(2'h0, 1'b0, 4'h2, 3'h0, 1'b0, 1'b0), 1'b0);
    repeat (3) cyc();
    ms(3'h0, mr0(2'h0, 1'b0, 4'h6, 3'h0, 1'b0, 1'b0), 1'b1);
    compare(o_read_latency, 4'ha, "replaced set");
    pulse(i_pd_enter);
    compare(o_dll_running, 1'b0, "slow pd");
    pulse(i_pd_exit);
    ms(3'h1, 19'h0, 1'b1);
    ms(3'h0, mr0(2'h0, 1'b0, 4'h1, 3'h1, 1'b1, 1'b1), 1'b1);
    compare({o_dll_reset, o_dll_locked}, 2'b10, "dll reset");
    wait_hi(o_dll_locked, 600, k);
    compare(k[15:0], 16'h0200, "lock time");
    pulse(i_pd_enter);
    compare(o_dll_running, 1'b1, "fast pd");
    pulse(i_pd_exit);
    pulse(i_sr_enter);
    compare({o_dll_running, o_dll_locked}, 2'b00, "sr entry");
    i_sr_exit = 1'b1;
    cyc();
    i_sr_exit = 1'b0;
    wait_hi(o_dll_reset, 4, k);
    ms(3'h1, 19'h00001, 1'b1);
    compare(o_dll_enabled, 1'b0, "dll off");
    pulse(i_sr_enter);
    pulse(i_sr_exit);
    repeat (4) begin
      cyc();
      compare({o_dll_enabled, o_dll_reset}, 2'b00, "dll kept off");
    end
    ms(3'h1, 19'h0, 1'b1);
    compare(o_dll_enabled, 1'b1, "dll on");
    ms(3'h0, mr0(2'h0, 1'b0, 4'h1, 3'h1, 1'b1, 1'b1), 1'b1);
    wait_hi(o_dll_locked, 600, k);
    burst(2'h2, 1'b0, 4'h1, 1'b0, 10'h003, 1'b0, 1'b0);
    burst(2'h0, 1'b1, 4'ha, 1'b0, 10'h2f7, 1'b1, 1'b1);
    burst(2'h1, 1'b0, 4'h2, 1'b1, 10'h1c5, 1'b0, 1'b0);
    for (j = 0; j < 24; j++) begin
      rs = lfsr(rs);
      burst((rs[1:0] == 2'h3) ? 2'h1 : rs[1:0], rs[2],
        (rs[6:3] % 4'ha) + 4'h1, rs[7], rs[17:8], rs[18], rs[19] & rs[20]);
    end
    i_reset_n = 1'b0;
    cyc();
    i_reset_n = 1'b1;
    compare({o_read_latency, o_write_recovery, o_dll_enabled, o_dll_locked,
      o_pd_slow_exit, o_cmd_ready}, 12'h50b, "second reset");
    final_report();
  end
  initial begin
    repeat (90000) @(posedge i_core_clk);
    give_up("run too long");
  end
endmodule : tb_top
`default_nettype wire
